/* phy_log_regs.vh */
// constants for the per-phy log descriptor block
`ifndef PHY_LOG_REGS_VH
`define PHY_LOG_REGS_VH
// register bus word offsets (byte addresses)
`define REG_STATUS 8'h00
`define REG_MASK 8'h04
`define REG_CTRL 8'h08
`define REG_GEN 8'h0c
// descriptor byte positions
`define BYTE_FLAGS_INIT 7'd14
`define BYTE_FLAGS_TGT 7'd15
`define BYTE_ADDR_LO 7'd16
`define BYTE_ADDR_HI 7'd23
`define BYTE_ATT_LO 7'd24
`define BYTE_ATT_HI 7'd31
`define BYTE_ATT_PHY 7'd32
`define BYTE_CNT0 7'd40
`define BYTE_EVLEN 7'd58
`define BYTE_EVNUM 7'd59
`define BYTE_EV0 7'd60
`define BYTE_LAST 7'd107
`define BYTE_TYPE_REASON 7'd12
`define BYTE_REASON_RATE 7'd13
// fixed field values
`define EV_DESC_LEN 8'h0c
`define EV_DESC_NUM 8'h04
`define EV_DESC_SIZE 7'd12
`define RATE_1G5 4'h8
`define RATE_3G0 4'h9
`define RATE_6G0 4'ha
`define GEN_UNKNOWN 8'h00
`define GEN_FIRST 8'h01
`define GEN_MAX 8'hff
// status bit positions
`define ST_IDENT 0
`define ST_SATA 1
`define ST_GEN 2
`define ST_SAT 3
`endif

/* event_counter.v */
// one 32-bit phy event counter, wrapping or saturating
`timescale 1ns/100ps
module event_counter #(
    parameter SATURATE = 0
) (
    // clock and control
    input wire clock_in,
    input wire rst_in,
    input wire ce_in,
    // count request
    input wire inc_in,
    output reg [31:0] count_out,
    output wire at_max_out
);
    assign at_max_out = (count_out == 32'hffffffff);

    // saturating counters hold at the top; wrapping ones roll to zero
    always @(posedge clock_in) begin
        if (rst_in) begin
            count_out <= 32'h00000000;
        end else if (ce_in && inc_in) begin
            if (!(SATURATE != 0 && at_max_out)) begin
                count_out <= count_out + 32'h00000001;
            end
        end
    end
endmodule // event_counter

/* sync_2ff.v */
// two flip-flop synchroniser for a bus of levels
`timescale 1ns/100ps
module sync_2ff #(
    parameter W = 1
) (
    // clock
    input wire clock_in,
    input wire rst_in,
    // data
    input wire [W-1:0] d_in,
    output reg [W-1:0] q_out
);
    reg [W-1:0] meta_ff;

    // first stage feeds only the second stage
    always @(posedge clock_in) begin
        if (rst_in) begin
            meta_ff <= {W{1'b0}};
            q_out <= {W{1'b0}};
        end else begin
            meta_ff <= d_in;
            q_out <= meta_ff;
        end
    end
endmodule // sync_2ff

/* sas_phy_log_descriptor.v */
// per-phy log descriptor assembly, bytes 12 to 107, with register port
//
// Behaviour
// R1: own target address in bytes 16-23, big-endian
// R2: attached address in bytes 24-31, big-endian
// R3: byte 58 holds event descriptor length 0ch
// R4: source 01h at 63, invalid dword count 64-67
// R5: source 02h at 75, disparity count 76-79
// R6: source 03h at 87, sync loss count 88-91
// R7: peak threshold words always read zero
// R8: attached device type from identification
// R9: SAS attachment: attached reason from last frame
// R10: SATA attachment: attached reason zero after first FIS
// R11: virtual phy: attached reason always zero
// R12: reason field from last transmitted frame
// R13: enabled phy reports rate codes 8h/9h/ah
// R14: four descriptors; fourth source 04h reset problem
// R15: invalid dwords outside reset counted, wrapping
// R16: disparity counts only in sync, saturates
// R17: generation code bumps on change, FFh wraps to 01h
// R18: reserved bytes zero, counters MSB first
// R19: bytes 14-15 hold received protocol flags
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`include "phy_log_regs.vh"
module sas_phy_log_descriptor (
    // clock, reset, enable
    input wire clock_in,
    input wire rst_in,
    input wire ce_in,
    // identification results from the link (same clock domain)
    input wire ident_done_in,
    input wire [2:0] att_dev_type_in,
    input wire [3:0] att_reason_in,
    input wire [2:0] att_init_flags_in,
    input wire [2:0] att_tgt_flags_in,
    input wire [63:0] att_addr_in,
    input wire [7:0] att_phy_id_in,
    input wire [3:0] tx_reason_in,
    input wire [63:0] own_addr_in,
    input wire [1:0] rate_in,
    input wire sata_attached_in,
    input wire sata_fis_in,
    input wire virtual_phy_in,
    // raw link event levels from the serial clock domain
    input wire bad_dword_in,
    input wire disparity_err_in,
    input wire sync_held_in,
    input wire in_reset_seq_in,
    input wire sync_lost_in,
    input wire reset_problem_in,
    input wire settings_changed_in,
    // descriptor read port
    input wire [6:0] desc_addr_in,
    input wire desc_rd_in,
    output reg [7:0] desc_data_out,
    // register port
    input wire [7:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [31:0] reg_rdata_out,
    // interrupt
    output reg irq_out
);
    // synchronised event levels
    wire [4:0] ev_sync;
    reg [4:0] ev_prev_ff;
    wire [4:0] ev_rise;
    wire sync_held_s;
    wire in_reset_s;

    sync_2ff #(.W(7)) u_sync (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .d_in({in_reset_seq_in, sync_held_in, settings_changed_in, reset_problem_in,
            sync_lost_in, disparity_err_in, bad_dword_in}),
        .q_out({in_reset_s, sync_held_s, ev_sync})
    );

    // edge detect on synchronised levels so a held level counts once
    always @(posedge clock_in) begin
        if (rst_in) begin
            ev_prev_ff <= 5'h00;
        end else if (ce_in) begin
            ev_prev_ff <= ev_sync;
        end
    end
    assign ev_rise = ev_sync & ~ev_prev_ff;

    // the four event counters
    wire [31:0] cnt_invalid;
    wire [31:0] cnt_disp;
    wire [31:0] cnt_sync;
    wire [31:0] cnt_rstp;
    wire disp_at_max;

    event_counter #(.SATURATE(0)) u_cnt_invalid (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .inc_in(ev_rise[0] && !in_reset_s), // R15
        .count_out(cnt_invalid),
        .at_max_out()
    );
    event_counter #(.SATURATE(1)) u_cnt_disp (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .inc_in(ev_rise[1] && sync_held_s), // R16
        .count_out(cnt_disp),
        .at_max_out(disp_at_max)
    );
    event_counter #(.SATURATE(0)) u_cnt_sync (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .inc_in(ev_rise[2]),
        .count_out(cnt_sync),
        .at_max_out()
    );
    event_counter #(.SATURATE(0)) u_cnt_rstp (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .inc_in(ev_rise[3]),
        .count_out(cnt_rstp),
        .at_max_out()
    );

    // identification results captured when the sequence completes
    reg [2:0] dev_type_ff;
    reg [3:0] att_reason_ff;
    reg [2:0] init_flags_ff;
    reg [2:0] tgt_flags_ff;
    reg [63:0] att_addr_ff;
    reg [7:0] att_phy_ff;
    reg [3:0] tx_reason_ff;
    reg [1:0] rate_ff;
    reg sata_ff;
    reg fis_seen_ff;
    reg ident_valid_ff;

    always @(posedge clock_in) begin
        if (rst_in) begin
            dev_type_ff <= 3'h0;
            att_reason_ff <= 4'h0;
            init_flags_ff <= 3'h0;
            tgt_flags_ff <= 3'h0;
            att_addr_ff <= 64'h0000000000000000;
            att_phy_ff <= 8'h00;
            tx_reason_ff <= 4'h0;
            rate_ff <= 2'h0;
            sata_ff <= 1'b0;
            fis_seen_ff <= 1'b0;
            ident_valid_ff <= 1'b0;
        end else if (ce_in) begin
            if (ident_done_in) begin
                dev_type_ff <= att_dev_type_in; // R8
                att_reason_ff <= att_reason_in; // R9
                init_flags_ff <= att_init_flags_in; // R19
                tgt_flags_ff <= att_tgt_flags_in; // R19
                att_addr_ff <= att_addr_in; // R2
                att_phy_ff <= att_phy_id_in;
                tx_reason_ff <= tx_reason_in; // R12
                rate_ff <= rate_in;
                sata_ff <= sata_attached_in;
                fis_seen_ff <= 1'b0;
                ident_valid_ff <= 1'b1;
            end else if (sata_ff && sata_fis_in) begin
                fis_seen_ff <= 1'b1; // R10
            end
        end
    end

    // control register: bit0 phy enable
    reg [31:0] ctrl_ff;
    reg [3:0] mask_ff;
    reg [3:0] status_ff;
    reg [7:0] gen_ff;
    wire phy_enabled = ctrl_ff[0];

    // attached reason per attachment kind
    function [3:0] att_reason_f;
        input virt;
        input sata;
        input fis_seen;
        input [3:0] rsn;
        begin
            if (virt) begin
                att_reason_f = 4'h0; // R11
            end else if (sata) begin
                att_reason_f = fis_seen ? 4'h0 : rsn; // R10
            end else begin
                att_reason_f = rsn; // R9
            end
        end
    endfunction

    // rate code; disabled phy reports zero
    function [3:0] rate_code_f;
        input en;
        input [1:0] r;
        begin
            if (!en) begin
                rate_code_f = 4'h0;
            end else begin
                case (r)
                    2'h0: rate_code_f = `RATE_1G5; // R13
                    2'h1: rate_code_f = `RATE_3G0; // R13
                    2'h2: rate_code_f = `RATE_6G0; // R13
                    default: rate_code_f = 4'h0;
                endcase
            end
        end
    endfunction

    // byte select within a 32-bit word, MSB first
    function [7:0] be_byte_f;
        input [31:0] w;
        input [1:0] idx;
        begin
            case (idx)
                2'h0: be_byte_f = w[31:24];
                2'h1: be_byte_f = w[23:16];
                2'h2: be_byte_f = w[15:8];
                default: be_byte_f = w[7:0];
            endcase
        end
    endfunction

    // descriptor byte mux
    reg [7:0] nxt_desc;
    reg [6:0] ev_off;
    reg [1:0] ev_idx;
    reg [31:0] ev_val;
    reg [2:0] addr_idx;

    always @* begin
        nxt_desc = 8'h00; // R18
        ev_off = 7'h00;
        ev_idx = 2'h0;
        ev_val = 32'h00000000;
        addr_idx = 3'h0;
        if (desc_addr_in == `BYTE_TYPE_REASON) begin
            nxt_desc = {1'b0, dev_type_ff, // R8
                att_reason_f(virtual_phy_in, sata_ff, fis_seen_ff, att_reason_ff)};
        end else if (desc_addr_in == `BYTE_REASON_RATE) begin
            nxt_desc = {tx_reason_ff, rate_code_f(phy_enabled, rate_ff)}; // R12
        end else if (desc_addr_in == `BYTE_FLAGS_INIT) begin
            nxt_desc = {4'h0, init_flags_ff, 1'b0}; // R19
        end else if (desc_addr_in == `BYTE_FLAGS_TGT) begin
            nxt_desc = {4'h0, tgt_flags_ff, 1'b0}; // R19
        end else if (desc_addr_in >= `BYTE_ADDR_LO && desc_addr_in <= `BYTE_ADDR_HI) begin
            addr_idx = desc_addr_in[2:0];
            nxt_desc = own_addr_in[8*(7-addr_idx) +: 8]; // R1
        end else if (desc_addr_in >= `BYTE_ATT_LO && desc_addr_in <= `BYTE_ATT_HI) begin
            addr_idx = desc_addr_in[2:0];
            nxt_desc = att_addr_ff[8*(7-addr_idx) +: 8]; // R2
        end else if (desc_addr_in == `BYTE_ATT_PHY) begin
            nxt_desc = att_phy_ff;
        end else if (desc_addr_in >= `BYTE_CNT0 && desc_addr_in < `BYTE_CNT0 + 7'd16) begin
            ev_off = desc_addr_in - `BYTE_CNT0;
            case (ev_off[3:2])
                2'h0: ev_val = cnt_invalid;
                2'h1: ev_val = cnt_disp;
                2'h2: ev_val = cnt_sync;
                default: ev_val = cnt_rstp;
            endcase
            nxt_desc = be_byte_f(ev_val, ev_off[1:0]); // R18
        end else if (desc_addr_in == `BYTE_EVLEN) begin
            nxt_desc = `EV_DESC_LEN; // R3
        end else if (desc_addr_in == `BYTE_EVNUM) begin
            nxt_desc = `EV_DESC_NUM; // R14
        end else if (desc_addr_in >= `BYTE_EV0 && desc_addr_in <= `BYTE_LAST) begin
            // each descriptor: 3 reserved, source, 4 value, 4 threshold
            ev_off = desc_addr_in - `BYTE_EV0;
            if (ev_off < `EV_DESC_SIZE) begin
                ev_idx = 2'h0;
            end else if (ev_off < 7'd24) begin
                ev_idx = 2'h1;
                ev_off = ev_off - 7'd12;
            end else if (ev_off < 7'd36) begin
                ev_idx = 2'h2;
                ev_off = ev_off - 7'd24;
            end else begin
                ev_idx = 2'h3;
                ev_off = ev_off - 7'd36;
            end
            case (ev_idx)
                2'h0: ev_val = cnt_invalid; // R4
                2'h1: ev_val = cnt_disp; // R5
                2'h2: ev_val = cnt_sync; // R6
                default: ev_val = cnt_rstp; // R14
            endcase
            if (ev_off == 7'd3) begin
                nxt_desc = {6'h00, ev_idx} + 8'h01; // R4 R5 R6 R14
            end else if (ev_off >= 7'd4 && ev_off <= 7'd7) begin
                nxt_desc = be_byte_f(ev_val, ev_off[1:0]); // R18
            end else begin
                nxt_desc = 8'h00; // R7
            end
        end
    end

    // descriptor read data one cycle after the strobe
    always @(posedge clock_in) begin
        if (rst_in) begin
            desc_data_out <= 8'h00;
        end else if (ce_in && desc_rd_in) begin
            desc_data_out <= nxt_desc;
        end
    end

    // events for the status register
    wire [3:0] evt = {disp_at_max && ev_rise[1] && sync_held_s, ev_rise[4],
        sata_ff && sata_fis_in && !fis_seen_ff, ident_done_in};

    // generation code, status, mask and control; set beats write-one clear
    always @(posedge clock_in) begin
        if (rst_in) begin
            gen_ff <= `GEN_UNKNOWN;
            status_ff <= 4'h0;
            mask_ff <= 4'h0;
            ctrl_ff <= 32'h00000000;
            irq_out <= 1'b0;
        end else if (ce_in) begin
            if (ev_rise[4]) begin
                gen_ff <= (gen_ff == `GEN_MAX) ? `GEN_FIRST : gen_ff + 8'h01; // R17
            end
            if (reg_wr_in && reg_addr_in == `REG_STATUS) begin
                status_ff <= (status_ff & ~reg_wdata_in[3:0]) | evt;
            end else begin
                status_ff <= status_ff | evt;
            end
            if (reg_wr_in && reg_addr_in == `REG_MASK) begin
                mask_ff <= reg_wdata_in[3:0];
            end
            if (reg_wr_in && reg_addr_in == `REG_CTRL) begin
                ctrl_ff <= {31'h00000000, reg_wdata_in[0]};
            end
            irq_out <= |(status_ff & mask_ff);
        end
    end

    // register read, data one cycle later; unmapped reads zero
    always @(posedge clock_in) begin
        if (rst_in) begin
            reg_rdata_out <= 32'h00000000;
        end else if (ce_in) begin
            if (reg_rd_in) begin
                case (reg_addr_in)
                    `REG_STATUS: reg_rdata_out <= {28'h0000000, status_ff};
                    `REG_MASK: reg_rdata_out <= {28'h0000000, mask_ff};
                    `REG_CTRL: reg_rdata_out <= {30'h00000000, ident_valid_ff, ctrl_ff[0]};
                    `REG_GEN: reg_rdata_out <= {24'h000000, gen_ff};
                    default: reg_rdata_out <= 32'h00000000;
                endcase
            end else begin
                reg_rdata_out <= 32'h00000000;
            end
        end
    end
endmodule // sas_phy_log_descriptor

/* sas_phy_log_descriptor_properties.sv */
// port checker for the per-phy log descriptor block
`timescale 1ns/100ps
module sas_phy_log_checker (
    // clock and reset
    input wire clock_in,
    input wire rst_in,
    input wire ce_in,
    // watched ports
    input wire [63:0] own_addr_in,
    input wire virtual_phy_in,
    input wire [6:0] desc_addr_in,
    input wire desc_rd_in,
    input wire [7:0] desc_data_out,
    input wire [7:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [31:0] reg_rdata_out,
    input wire irq_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // decode of the byte being read; off is only meaningful inside the event list
    wire take = desc_rd_in && ce_in;
    wire in_ev = desc_addr_in >= 7'h3c && desc_addr_in <= 7'h6b;
    wire [6:0] off = (desc_addr_in - 7'h3c) % 7'h0c;
    wire zero_byte = desc_addr_in < 7'h0c || desc_addr_in > 7'h6b || desc_addr_in == 7'h38
        || desc_addr_in == 7'h39 || (desc_addr_in >= 7'h21 && desc_addr_in <= 7'h27)
        || (in_ev && (off < 7'h3 || off > 7'h7));
    rdata_idle_a: assert property (!(reg_rd_in && ce_in) |=> reg_rdata_out == 32'h0)
        else $error("register read data not zero outside a read");
    unmapped_read_a: assert property (reg_rd_in && ce_in
        && !(reg_addr_in inside {8'h00, 8'h04, 8'h08, 8'h0c}) |=> reg_rdata_out == 32'h0)
        else $error("unmapped register read not zero");
    irq_masked_a: assert property (reg_wr_in && ce_in && reg_addr_in == 8'h04
        && reg_wdata_in == 32'h0 |-> ##2 !irq_out)
        else $error("interrupt high with mask cleared");
    ev_len_a: assert property (take && desc_addr_in == 7'h3a |=> desc_data_out == 8'h0c)
        else $error("event length byte wrong");
    ev_num_a: assert property (take && desc_addr_in == 7'h3b |=> desc_data_out == 8'h04)
        else $error("event count byte wrong");
    src_code_a: assert property (take && in_ev && off == 7'h3
        |=> desc_data_out == 8'((($past(desc_addr_in) - 7'h3c) / 7'h0c) + 7'h1))
        else $error("event source code wrong");
    own_addr_a: assert property (take && desc_addr_in >= 7'h10 && desc_addr_in <= 7'h17
        |=> desc_data_out == 8'($past(own_addr_in) >> (8 * (7'h17 - $past(desc_addr_in)))))
        else $error("own address byte wrong");
    zero_byte_a: assert property (take && zero_byte |=> desc_data_out == 8'h00)
        else $error("reserved or threshold byte not zero");
    desc_hold_a: assert property (!take |=> $stable(desc_data_out))
        else $error("descriptor data changed without a read");
    virt_reason_a: assert property (take && desc_addr_in == 7'h0c && virtual_phy_in
        |=> desc_data_out[3:0] == 4'h0)
        else $error("virtual phy attached reason not zero");
    // main scenarios reached
    cover property ($rose(irq_out));
    cover property (take && desc_addr_in == 7'h63);
    cover property (reg_rd_in && reg_addr_in == 8'h0c);
endmodule // sas_phy_log_checker

bind sas_phy_log_descriptor sas_phy_log_checker chk (.clock_in(clock_in), .rst_in(rst_in),
    .ce_in(ce_in), .own_addr_in(own_addr_in), .virtual_phy_in(virtual_phy_in),
    .desc_addr_in(desc_addr_in), .desc_rd_in(desc_rd_in), .desc_data_out(desc_data_out),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .irq_out(irq_out));

/* link_partner_model.sv */
// behavioural model of the attached phy and its link event levels
`timescale 1ns/100ps
module link_partner_model (
    // clock
    input wire clock_in,
    // identification results, packed type..sata
    output logic done_out = 1'b0,
    output logic [91:0] id_out = 92'h0,
    output logic fis_out = 1'b0,
    // event levels {settings, reset problem, sync lost, disparity, bad dword}
    output logic [4:0] ev_out = 5'h0,
    output logic [1:0] qual_out = 2'h0
);
    // fields only hold at the capture edge; inverted after so a late sample is caught
    task automatic identify(input logic [91:0] v);
        @(posedge clock_in);
        id_out <= v;
        done_out <= 1'b1;
        @(posedge clock_in);
        done_out <= 1'b0;
        id_out <= ~v;
    endtask
    // one register frame seen from a sata device
    task automatic fis;
        @(posedge clock_in);
        fis_out <= 1'b1;
        @(posedge clock_in);
        fis_out <= 1'b0;
    endtask
    // qualifiers {in reset sequence, sync held}
    task automatic qualify(input logic [1:0] q);
        qual_out <= q;
    endtask
    // n pulses, three cycles high and four low between them so the synchroniser sees each
    task automatic pulse(input int i, input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge clock_in);
            ev_out <= ev_out | (5'h01 << i);
            repeat (3) @(posedge clock_in);
            ev_out <= ev_out & ~(5'h01 << i);
            repeat (3) @(posedge clock_in);
        end
    endtask
endmodule // link_partner_model

/* sas_phy_log_descriptor_bench.sv */
// self-checking bench for the per-phy log descriptor block
`timescale 1ns/100ps
module sas_phy_log_descriptor_bench;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic virtual_phy_in = 1'b0;
    logic [63:0] own_addr_in = 64'h0123456789abcdef;
    logic [6:0] desc_addr_in = 7'h0;
    logic desc_rd_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h0;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    wire [7:0] desc_data_out;
    wire [31:0] reg_rdata_out;
    wire irq_out;
    wire done;
    wire fis;
    wire [91:0] id;
    wire [4:0] ev;
    wire [1:0] qual;
    int fail_count = 0;
    int checks_done = 0;
    localparam logic [63:0] att_addr = 64'hfedcba9876543210;
    // byte number beside expected value after a sas identify with rate 3g
    logic [14:0] rows [0:19] = '{{7'h0c, 8'h25}, {7'h0d, 8'h39}, {7'h0e, 8'h0a}, {7'h0f, 8'h04},
        {7'h20, 8'h07}, {7'h3a, 8'h0c}, {7'h3b, 8'h04}, {7'h3f, 8'h01}, {7'h4b, 8'h02},
        {7'h57, 8'h03}, {7'h63, 8'h04}, {7'h21, 8'h00}, {7'h27, 8'h00}, {7'h38, 8'h00},
        {7'h3c, 8'h00}, {7'h47, 8'h00}, {7'h53, 8'h00}, {7'h5f, 8'h00}, {7'h6b, 8'h00},
        {7'h6c, 8'h00}};
    always #2.5 clock_in = ~clock_in;
    link_partner_model lp (.clock_in(clock_in), .done_out(done), .id_out(id), .fis_out(fis),
        .ev_out(ev), .qual_out(qual));
    sas_phy_log_descriptor DUT (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in),
        .ident_done_in(done), .att_dev_type_in(id[91:89]), .att_reason_in(id[88:85]),
        .att_init_flags_in(id[84:82]), .att_tgt_flags_in(id[81:79]), .att_addr_in(id[78:15]),
        .att_phy_id_in(id[14:7]), .tx_reason_in(id[6:3]), .rate_in(id[2:1]),
        .sata_attached_in(id[0]), .sata_fis_in(fis), .virtual_phy_in(virtual_phy_in),
        .bad_dword_in(ev[0]), .disparity_err_in(ev[1]), .sync_held_in(qual[0]),
        .in_reset_seq_in(qual[1]), .sync_lost_in(ev[2]), .reset_problem_in(ev[3]),
        .settings_changed_in(ev[4]), .own_addr_in(own_addr_in), .desc_addr_in(desc_addr_in),
        .desc_rd_in(desc_rd_in), .desc_data_out(desc_data_out), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .irq_out(irq_out));
    // verdict; the only place the run ends
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_word(what, {24'h0, exp}, {24'h0, got});
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        #1 check_word($sformatf("reg %h", a), exp, reg_rdata_out);
    endtask
    task automatic desc(input logic [6:0] a, input logic [7:0] exp);
        @(posedge clock_in);
        desc_addr_in <= a;
        desc_rd_in <= 1'b1;
        @(posedge clock_in);
        desc_rd_in <= 1'b0;
        #1 check_byte($sformatf("byte %0d", a), exp, desc_data_out);
    endtask
    // watchdog well beyond the few thousand cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clock_in);
        fail_count++;
        test_done();
    end
    initial begin
        repeat (16) @(posedge clock_in);
        rst_in <= 1'b0;
        reg_read(8'h0c, 32'h0);
        reg_read(8'h00, 32'h0);
        reg_read(8'h10, 32'h0);
        reg_write(8'h04, 32'h1);
        lp.identify({3'd2, 4'h5, 3'b101, 3'b010, att_addr, 8'h07, 4'h3, 2'd1, 1'b0});
        desc(7'h0d, 8'h30);
        for (int i = 0; i < 8 && irq_out !== 1'b1; i++)
            #5;
        check_byte("irq raised", 8'h1, {7'h0, irq_out});
        reg_write(8'h00, 32'h1);
        reg_write(8'h04, 32'h0);
        reg_read(8'h00, 32'h0);
        check_byte("irq cleared", 8'h0, {7'h0, irq_out});
        reg_write(8'h08, 32'h1);
        for (int r = 0; r < 4; r++) begin
            lp.identify({3'd2, 4'h5, 3'b101, 3'b010, att_addr, 8'h07, 4'h3, 2'(r), 1'b0});
            desc(7'h0d, r == 3 ? 8'h30 : 8'h38 + 8'(r));
        end
        lp.identify({3'd2, 4'h5, 3'b101, 3'b010, att_addr, 8'h07, 4'h3, 2'd1, 1'b0});
        for (int i = 0; i < 8; i++) begin
            desc(7'(16 + i), own_addr_in[63 - 8 * i -: 8]);
            desc(7'(24 + i), att_addr[63 - 8 * i -: 8]);
        end
        for (int i = 0; i < 20; i++)
            desc(rows[i][14:8], rows[i][7:0]);
        virtual_phy_in <= 1'b1;
        desc(7'h0c, 8'h20);
        virtual_phy_in <= 1'b0;
        // counting with sync held and outside reset, then the opposite qualifiers
        lp.qualify(2'b01);
        lp.pulse(0, 3);
        lp.pulse(1, 2);
        lp.pulse(2, 1);
        lp.pulse(3, 1);
        lp.pulse(4, 2);
        lp.qualify(2'b10);
        lp.pulse(0, 1);
        lp.pulse(1, 1);
        desc(7'h43, 8'h03);
        desc(7'h2b, 8'h03);
        desc(7'h40, 8'h00);
        desc(7'h4f, 8'h02);
        desc(7'h5b, 8'h01);
        desc(7'h67, 8'h01);
        reg_read(8'h0c, 32'h2);
        // 254 more changes run the code past ffh onto 01h, never 00h
        lp.pulse(4, 254);
        reg_read(8'h0c, 32'h1);
        // sata attachment: reason held until the first frame, then zero
        lp.identify({3'd1, 4'h6, 3'b010, 3'b000, att_addr, 8'h07, 4'h3, 2'd1, 1'b1});
        desc(7'h0c, 8'h16);
        lp.fis();
        desc(7'h0c, 8'h10);
        check_byte("irq masked", 8'h0, {7'h0, irq_out});
        // clock enable low: a read strobe is ignored and the byte stands
        @(posedge clock_in);
        ce_in <= 1'b0;
        desc(7'h3f, 8'h10);
        @(posedge clock_in);
        ce_in <= 1'b1;
        // reset in mid-run clears counters, control and the generation code
        rst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        reg_read(8'h0c, 32'h0);
        reg_read(8'h08, 32'h0);
        check_byte("irq after reset", 8'h0, {7'h0, irq_out});
        desc(7'h2b, 8'h00);
        desc(7'h0d, 8'h00);
        test_done();
    end
endmodule // sas_phy_log_descriptor_bench
